// *** common/alarm_cond_pkg.sv ***
// package: constants and types for the input channel alarm conditioner
package alarm_cond_pkg;
  localparam int NCH = 4; // input channels
  localparam int NAL = 4; // alarm comparators per channel
  localparam int AW = 9; // avalon byte address width
  // alarm slots within a channel
  localparam int AL_HH = 0;
  localparam int AL_H = 1;
  localparam int AL_L = 2;
  localparam int AL_LL = 3;
  // address map: block 0 global, blocks 1..NCH channels
  localparam logic [2:0] BLK_GLB = 3'h0;
  localparam logic [5:0] GLB_CTRL = 6'h00;
  localparam logic [5:0] REG_CFG = 6'h00;
  localparam logic [5:0] REG_OFFSET = 6'h04;
  localparam logic [5:0] REG_LIM0 = 6'h08; // four limits, hh h l ll
  localparam logic [5:0] REG_BAND0 = 6'h18; // four deadbands, same order
  localparam logic [5:0] REG_ITIME = 6'h28;
  localparam logic [5:0] REG_STATUS = 6'h2c;
  localparam logic [5:0] REG_VALUE = 6'h30;
  // channel config fields
  localparam int CFG_W = 12;
  localparam int CFG_FILT = 0;
  localparam int CFG_DIAG = 1;
  localparam int CFG_FAULT = 2;
  localparam int CFG_DMASK = 4;
  localparam int CFG_FMASK = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000; // offset, limits, itime
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COND = 4'b0010,
    ST_EVAL = 4'b0100,
    ST_REPORT = 4'b1000
  } state_type;
endpackage : alarm_cond_pkg

// *** rtl/alarm_hyst.sv ***
// one alarm comparator with hysteresis deadband
`timescale 1ns/10ps
module alarm_hyst
  import alarm_cond_pkg::*;
(
  input wire logic [31:0] value_i,
  input wire logic [31:0] limit_i,
  input wire logic [31:0] band_i,
  input wire logic high_i,
  input wire logic active_i,
  output logic next_o
);
  // widened so limit plus deadband cannot wrap
  logic signed [33:0] v;
  logic signed [33:0] lim;
  logic signed [33:0] bnd;
  logic trip;
  logic clr;
  assign v = 34'(signed'(value_i));
  assign lim = 34'(signed'(limit_i));
  assign bnd = 34'(signed'(band_i));
  // high type trips at or above, low type at or below
  assign trip = high_i ? (v >= lim) : (v <= lim);
  // clears only once outside the deadband band
  assign clr = high_i ? (v < lim - bnd) : (v > lim + bnd);
  assign next_o = active_i ? !clr : trip;
endmodule : alarm_hyst

// *** rtl/alarm_cond.sv ***
// input channel offset, filter, four-level alarm and report logic
// How it works
// [R1] offset added to scaled value before compare
// [R2] software keeps offset inside format range
// [R3] high-high and low-low trip at threshold
// [R4] software orders thresholds ll<l<h<hh
// [R5] high and low trip at threshold
// [R6] alarm holds until input leaves deadband
// [R7] evaluate only with diag or fault enabled
// [R8] software keeps deadband clear point reachable
// [R9] filter only when channel filter enabled
// [R10] first-order filter, integration time constant
// [R11] integration time zero passes input unfiltered
// [R12] diag memory gets masked alarm status
// [R13] channel diag needs module diag enable
// [R14] one fault entry per alarm occurrence
// [R15] evaluate once per sample, filtered value
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module alarm_cond
  import alarm_cond_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sample_valid_i,
  input wire logic [1:0] sample_ch_i,
  input wire logic [31:0] sample_data_i,
  output logic sample_ready_o,
  output logic diag_wr_o,
  output logic [1:0] diag_ch_o,
  output logic [NAL-1:0] diag_bits_o,
  output logic fault_valid_o,
  output logic [1:0] fault_ch_o,
  output logic [1:0] fault_type_o
);
  // all state of the block
  typedef struct packed {
    state_type st;
    logic [1:0] ch; // channel in work
    logic [31:0] x; // latched sample
    logic [NAL-1:0] pend; // fault entries still to emit
    logic mod_diag; // module level diag enable
    logic [NCH-1:0][CFG_W-1:0] cfg;
    logic [NCH-1:0][31:0] off;
    logic [NCH-1:0][31:0] itime;
    logic [NCH-1:0][31:0] val; // filtered, offset value
    logic [NCH-1:0][NAL-1:0][31:0] lim;
    logic [NCH-1:0][NAL-1:0][31:0] band;
    logic [NCH-1:0][NAL-1:0] stat; // alarm status bits
    logic wt; // waitrequest
    logic [31:0] rdata;
    logic diag_wr;
    logic [1:0] diag_ch;
    logic [NAL-1:0] diag_bits;
    logic flt_v;
    logic [1:0] flt_ch;
    logic [1:0] flt_ty;
    logic rdy;
  } core_type;

  core_type core_r;
  core_type core_nxt;

  // byte lane merge for writes
  function automatic logic [31:0] lane(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : lane

  // index of highest set bit, sets the filter shift
  function automatic logic [4:0] msb(input logic [31:0] t);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (t[i])
        r = 5'(i);
    end
    return r;
  endfunction : msb

  // helpers for bus address decode and the channel in work
  logic [2:0] blk;
  logic [5:0] ofs;
  logic [1:0] bch;
  logic [32:0] sum;
  logic [31:0] xo;
  logic [31:0] cur_val;
  logic signed [32:0] fdiff;
  logic [31:0] yf;
  logic fon;
  logic diag_on;
  logic fault_on;
  logic eval_on;
  logic [NAL-1:0] ns;

  assign blk = avs_address_i[8:6];
  assign ofs = {avs_address_i[5:2], 2'b00};
  assign bch = 2'(blk - 3'h1);
  assign cur_val = core_r.val[core_r.ch];
  // offset add, saturated to 32 bits
  assign sum = 33'(signed'(core_r.x)) + 33'(signed'(core_r.off[core_r.ch])); // [R1]
  assign xo = (sum[32] != sum[31]) ? {sum[32], {31{!sum[32]}}} : sum[31:0];
  // filter on only when enabled and time nonzero
  assign fon = core_r.cfg[core_r.ch][CFG_FILT] && (core_r.itime[core_r.ch] != WORD_RST); // [R9] [R11]
  // y += (x - y) / 2^k, k from time in one-ms samples
  assign fdiff = 33'(signed'(xo)) - 33'(signed'(cur_val));
  assign yf = 32'(33'(signed'(cur_val)) + (fdiff >>> msb(core_r.itime[core_r.ch]))); // [R10]
  // reporting enables, channel diag gated by module diag
  assign diag_on = core_r.mod_diag && core_r.cfg[core_r.ch][CFG_DIAG]; // [R13]
  assign fault_on = core_r.cfg[core_r.ch][CFG_FAULT];
  assign eval_on = diag_on || fault_on; // [R7]

  // four comparators share the channel in work
  for (genvar a = 0; a < NAL; a++)
  begin : g_cmp
    alarm_hyst u_cmp (
      .value_i(cur_val),
      .limit_i(core_r.lim[core_r.ch][a]),
      .band_i(core_r.band[core_r.ch][a]),
      .high_i(a < AL_L),
      .active_i(core_r.stat[core_r.ch][a]),
      .next_o(ns[a])
    ); // [R3] [R5] [R6]
  end

  // next state: bus slave and sample sequencer
  always_comb
  begin
    core_nxt = core_r;
    core_nxt.diag_wr = 1'b0;
    core_nxt.flt_v = 1'b0;
    // bus: one wait cycle, then answer
    if ((avs_read_i || avs_write_i) && core_r.wt)
    begin
      core_nxt.wt = 1'b0;
      core_nxt.rdata = WORD_RST; // unmapped reads zero
      if (blk == BLK_GLB && ofs == GLB_CTRL)
        core_nxt.rdata = {31'h0000_0000, core_r.mod_diag};
      else if (blk != BLK_GLB && blk <= 3'(NCH))
      begin
        if (ofs == REG_CFG)
          core_nxt.rdata = 32'(core_r.cfg[bch]);
        else if (ofs == REG_OFFSET)
          core_nxt.rdata = core_r.off[bch];
        else if (ofs >= REG_LIM0 && ofs < REG_BAND0)
          core_nxt.rdata = core_r.lim[bch][ofs[3:2] - 2'h2];
        else if (ofs >= REG_BAND0 && ofs < REG_ITIME)
          core_nxt.rdata = core_r.band[bch][ofs[3:2] - 2'h2];
        else if (ofs == REG_ITIME)
          core_nxt.rdata = core_r.itime[bch];
        else if (ofs == REG_STATUS)
          core_nxt.rdata = 32'(core_r.stat[bch]);
        else if (ofs == REG_VALUE)
          core_nxt.rdata = core_r.val[bch];
      end
    end
    else
      core_nxt.wt = 1'b1;
    // write lands at the edge where waitrequest is low
    if (avs_write_i && !core_r.wt)
    begin
      if (blk == BLK_GLB && ofs == GLB_CTRL && avs_byteenable_i[0])
        core_nxt.mod_diag = avs_writedata_i[0];
      else if (blk != BLK_GLB && blk <= 3'(NCH))
      begin
        if (ofs == REG_CFG)
          core_nxt.cfg[bch] = CFG_W'(lane(32'(core_r.cfg[bch]), avs_writedata_i, avs_byteenable_i));
        else if (ofs == REG_OFFSET)
          core_nxt.off[bch] = lane(core_r.off[bch], avs_writedata_i, avs_byteenable_i);
        else if (ofs >= REG_LIM0 && ofs < REG_BAND0)
          core_nxt.lim[bch][ofs[3:2] - 2'h2] =
            lane(core_r.lim[bch][ofs[3:2] - 2'h2], avs_writedata_i, avs_byteenable_i);
        else if (ofs >= REG_BAND0 && ofs < REG_ITIME)
          core_nxt.band[bch][ofs[3:2] - 2'h2] =
            lane(core_r.band[bch][ofs[3:2] - 2'h2], avs_writedata_i, avs_byteenable_i);
        else if (ofs == REG_ITIME)
          core_nxt.itime[bch] = lane(core_r.itime[bch], avs_writedata_i, avs_byteenable_i);
      end
    end
    // sequencer: one pass per accepted sample
    case (core_r.st)
      ST_IDLE:
      begin
        if (sample_valid_i && core_r.rdy)
        begin
          core_nxt.x = sample_data_i;
          core_nxt.ch = sample_ch_i;
          core_nxt.st = ST_COND;
        end
      end
      ST_COND:
      begin
        // offset then filter, stored as the channel value
        core_nxt.val[core_r.ch] = fon ? yf : xo; // [R1] [R9] [R10] [R11] [R15]
        core_nxt.st = ST_EVAL;
      end
      ST_EVAL:
      begin
        core_nxt.pend = '0;
        if (eval_on) // [R7]
        begin
          core_nxt.stat[core_r.ch] = ns; // [R15]
          // only new occurrences make fault entries
          if (fault_on)
            core_nxt.pend = ns & ~core_r.stat[core_r.ch] &
              core_r.cfg[core_r.ch][CFG_FMASK +: NAL]; // [R14]
        end
        if (diag_on)
        begin
          core_nxt.diag_wr = 1'b1; // [R12]
          core_nxt.diag_ch = core_r.ch;
          core_nxt.diag_bits = ns & core_r.cfg[core_r.ch][CFG_DMASK +: NAL]; // [R12]
        end
        core_nxt.st = ST_REPORT;
      end
      ST_REPORT:
      begin
        // drain one fault entry per cycle, lowest slot first
        if (core_r.pend != '0)
        begin
          for (int i = NAL - 1; i >= 0; i--)
          begin
            if (core_r.pend[i])
              core_nxt.flt_ty = 2'(i);
          end
          core_nxt.flt_v = 1'b1; // [R14]
          core_nxt.flt_ch = core_r.ch;
          core_nxt.pend[core_nxt.flt_ty] = 1'b0;
        end
        else
          core_nxt.st = ST_IDLE;
      end
      default:
        core_nxt.st = ST_IDLE;
    endcase
    core_nxt.rdy = (core_nxt.st == ST_IDLE);
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      core_r <= '0;
      core_r.st <= ST_IDLE;
      core_r.wt <= 1'b1;
      core_r.rdy <= 1'b1;
      core_r.cfg <= {NCH{CFG_RST}};
    end
    else
      core_r <= core_nxt;
  end

  // outputs straight from flops
  assign avs_readdata_o = core_r.rdata;
  assign avs_waitrequest_o = core_r.wt;
  assign sample_ready_o = core_r.rdy;
  assign diag_wr_o = core_r.diag_wr;
  assign diag_ch_o = core_r.diag_ch;
  assign diag_bits_o = core_r.diag_bits;
  assign fault_valid_o = core_r.flt_v;
  assign fault_ch_o = core_r.flt_ch;
  assign fault_type_o = core_r.flt_ty;

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_offset_raw: assert property ( // [R1] [R11]
    core_r.st == ST_COND && !fon |=> cur_val == $past(xo))
    else $error("unfiltered value is not sample plus offset");
  // a step smaller than the time constant may legally shift to nothing, so only larger steps count
  a_filter_step: assert property ( // [R10]
    core_r.st == ST_COND && fon && core_r.itime[core_r.ch] > 32'h0000_0001 &&
    fdiff >= $signed({1'b0, core_r.itime[core_r.ch]})
    |=> cur_val != $past(xo) && $signed(cur_val) > $signed($past(cur_val)))
    else $error("filter did not take a partial step");
  a_hh_trip: assert property ( // [R3]
    core_r.st == ST_EVAL && eval_on && $signed(cur_val) >= $signed(core_r.lim[core_r.ch][AL_HH])
    |=> core_r.stat[core_r.ch][AL_HH])
    else $error("high-high alarm missed");
  a_ll_trip: assert property ( // [R3]
    core_r.st == ST_EVAL && eval_on && $signed(cur_val) <= $signed(core_r.lim[core_r.ch][AL_LL])
    |=> core_r.stat[core_r.ch][AL_LL])
    else $error("low-low alarm missed");
  // high and low checked apart: with ordered limits both can never trip together
  a_h_trip: assert property ( // [R5]
    core_r.st == ST_EVAL && eval_on && $signed(cur_val) >= $signed(core_r.lim[core_r.ch][AL_H])
    |=> core_r.stat[core_r.ch][AL_H])
    else $error("high alarm missed");
  a_l_trip: assert property ( // [R5]
    core_r.st == ST_EVAL && eval_on && $signed(cur_val) <= $signed(core_r.lim[core_r.ch][AL_L])
    |=> core_r.stat[core_r.ch][AL_L])
    else $error("low alarm missed");
  a_high_hold: assert property ( // [R6]
    core_r.st == ST_EVAL && eval_on && core_r.stat[core_r.ch][AL_H] &&
    34'(signed'(cur_val)) >= 34'(signed'(core_r.lim[core_r.ch][AL_H])) -
    34'(signed'(core_r.band[core_r.ch][AL_H])) |=> core_r.stat[core_r.ch][AL_H])
    else $error("high alarm cleared inside deadband");
  a_eval_gated: assert property ( // [R7]
    core_r.st == ST_EVAL && !eval_on |=> core_r.stat[core_r.ch] == $past(core_r.stat[core_r.ch]))
    else $error("alarm evaluated with reporting off");
  a_diag_write: assert property ( // [R12] [R13]
    core_r.st == ST_EVAL |=> diag_wr_o == $past(diag_on) &&
    (!diag_wr_o || diag_bits_o == (core_r.stat[core_r.ch] & core_r.cfg[core_r.ch][CFG_DMASK +: NAL])))
    else $error("diag write wrong");
  a_fault_gate: assert property ( // [R14]
    fault_valid_o |-> core_r.cfg[fault_ch_o][CFG_FAULT] && core_r.cfg[fault_ch_o][CFG_FMASK + fault_type_o]
    && core_r.stat[fault_ch_o][fault_type_o])
    else $error("fault entry without enabled alarm");
  a_one_pass: assert property ( // [R15]
    sample_valid_i && sample_ready_o |=> core_r.st == ST_COND ##1 core_r.st == ST_EVAL ##1 core_r.st == ST_REPORT)
    else $error("sample not evaluated in sequence");
  a_bus_wait: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");

  c_diag: cover property (diag_wr_o && diag_bits_o != '0);
  c_fault: cover property (fault_valid_o ##1 fault_valid_o);
  c_filter: cover property (core_r.st == ST_COND && fon);
  c_clear: cover property (core_r.st == ST_EVAL && core_r.stat[core_r.ch][AL_H] && eval_on
    ##1 !core_r.stat[core_r.ch][AL_H]);
endmodule : alarm_cond

// *** verif/cpu_bus_model.sv ***
// avalon-mm master model standing in for the controlling cpu
`timescale 1ns/10ps
module cpu_bus_model
  import alarm_cond_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [AW-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  output logic hang_o // raised when the slave never answers
);
  // idle bus at time zero
  initial
  begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0000_0000;
    avs_byteenable_o = 4'h0;
    hang_o = 1'b0;
  end

  // one word transfer; request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd, input logic [3:0] bl,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_o <= a;
    avs_writedata_o <= wd;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    avs_byteenable_o <= bl; // lanes held with the request
    // bounded wait: a dead slave must not hang the run
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_i !== 1'b0 && n < 50);
    rd = avs_readdata_i;
    if (n >= 50)
      hang_o <= 1'b1;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // stale data is not left on the bus after release
    avs_writedata_o <= ~wd;
  endtask : xfer
endmodule : cpu_bus_model

// *** verif/input_channel_alarm_conditioner_bench.sv ***
// self-checking bench for the alarm conditioner against a behavioural reference
`timescale 1ns/10ps
module input_channel_alarm_conditioner_bench;
  import alarm_cond_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [AW-1:0] addr;
  logic rd_s, wr_s, wait_s, hang, s_ready, d_wr, f_valid;
  logic [31:0] wdata, rdata;
  logic [3:0] be, d_bits;
  logic s_valid = 1'b0;
  logic [1:0] s_ch = 2'h0;
  logic [31:0] s_data = 32'h0000_0000;
  logic [1:0] d_ch, f_ch, f_type;
  int fails = 0;
  int checked = 0;
  // reference state, mirrors what software wrote
  int off[NCH], lim[NCH][NAL], band[NCH][NAL], itime[NCH], fy[NCH];
  logic [11:0] cfg[NCH] = '{default: '0};
  logic [3:0] st[NCH] = '{default: '0};
  logic mdiag = 1'b0;
  logic [7:0] got_q[$], exp_q[$]; // kind, channel, payload
  int xs[12] = '{490, 989, 990, 891, 889, 389, -510, -1010, -909, -389, -911, 0};

  always #10 sys_clk_i = ~sys_clk_i;

  alarm_cond alarm_cond_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_s), .sample_valid_i(s_valid), .sample_ch_i(s_ch), .sample_data_i(s_data),
    .sample_ready_o(s_ready), .diag_wr_o(d_wr), .diag_ch_o(d_ch), .diag_bits_o(d_bits),
    .fault_valid_o(f_valid), .fault_ch_o(f_ch), .fault_type_o(f_type));
  cpu_bus_model cpu_bus_model_inst (.sys_clk_i(sys_clk_i), .avs_waitrequest_i(wait_s), .avs_readdata_i(rdata),
    .avs_address_o(addr), .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdata),
    .avs_byteenable_o(be), .hang_o(hang));

  // collect every report pulse in arrival order
  always @(posedge sys_clk_i)
  begin
    if (d_wr === 1'b1)
      got_q.push_back({2'b01, d_ch, d_bits});
    if (f_valid === 1'b1)
      got_q.push_back({2'b10, f_ch, 2'b00, f_type});
  end

  // a dead bus ends the run
  always @(posedge hang)
  begin
    fails++;
    final_report();
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic wr(input logic [AW-1:0] a, input int d, input logic [3:0] bl = 4'hf);
    logic [31:0] r;
    cpu_bus_model_inst.xfer(1'b1, a, 32'(d), bl, r);
  endtask : wr

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] e);
    logic [31:0] r;
    cpu_bus_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'hf, r);
    check(r, e);
  endtask : rdchk

  function automatic logic [AW-1:0] ra(input int c, input logic [5:0] r);
    return AW'(64 * (c + 1)) + AW'(r);
  endfunction : ra

  // ordered limits hh > h > l > ll, band keeps clear point in range
  task automatic set_ch(input int c, input logic [11:0] cf, input int o, input int it, input int h, input int b);
    cfg[c] = cf;
    off[c] = o;
    itime[c] = it;
    lim[c] = '{h, h / 2, -h / 2, -h};
    wr(ra(c, REG_CFG), cf);
    wr(ra(c, REG_OFFSET), o);
    wr(ra(c, REG_ITIME), it);
    for (int i = 0; i < NAL; i++)
    begin
      band[c][i] = b;
      wr(ra(c, REG_LIM0) + AW'(4 * i), lim[c][i]);
      wr(ra(c, REG_BAND0) + AW'(4 * i), b);
    end
  endtask : set_ch

  // reference: offset, filter, hysteresis compare, diag and fault reports
  task automatic model(input int c, input int x);
    logic [3:0] ns;
    int v;
    v = x + off[c];
    if (cfg[c][CFG_FILT] && itime[c] != 0)
      fy[c] = fy[c] + ((v - fy[c]) >>> ($clog2(itime[c] + 1) - 1));
    else
      fy[c] = v;
    if ((mdiag && cfg[c][CFG_DIAG]) || cfg[c][CFG_FAULT])
    begin
      for (int i = 0; i < NAL; i++)
        if (i < 2)
          ns[i] = st[c][i] ? (fy[c] >= lim[c][i] - band[c][i]) : (fy[c] >= lim[c][i]);
        else
          ns[i] = st[c][i] ? (fy[c] <= lim[c][i] + band[c][i]) : (fy[c] <= lim[c][i]);
      if (mdiag && cfg[c][CFG_DIAG])
        exp_q.push_back({2'b01, 2'(c), ns & cfg[c][7:4]});
      for (int i = 0; i < NAL; i++)
        if (ns[i] && !st[c][i] && cfg[c][CFG_FAULT] && cfg[c][CFG_FMASK + i])
          exp_q.push_back({2'b10, 2'(c), 2'b00, 2'(i)});
      st[c] = ns;
    end
  endtask : model

  // one sample, then compare every report it produced
  task automatic send(input int c, input int x);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_valid <= 1'b1;
    s_ch <= 2'(c);
    s_data <= 32'(x);
    @(posedge sys_clk_i);
    s_valid <= 1'b0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (s_ready !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      fails++;
      final_report();
    end
    model(c, x);
    check(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      check(32'(got_q[i]), 32'(exp_q[i]));
    got_q.delete();
    exp_q.delete();
  endtask : send

  initial
  begin
    void'($urandom(32'h8a28));
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdchk(9'h000, 32'h0000_0000);
    for (int r = 0; r < 13; r++)
      rdchk(ra(3, 6'(4 * r)), 32'h0000_0000);
    wr(9'h180, 32'hffff_ffff);
    rdchk(9'h180, 32'h0000_0000);
    // partial lanes: only enabled bytes of a word change
    wr(ra(3, REG_OFFSET), 32'h1234_5678, 4'h5);
    rdchk(ra(3, REG_OFFSET), 32'h0034_0078);
    wr(ra(3, REG_OFFSET), 0);
    wr(9'h000, 1, 4'he);
    rdchk(9'h000, 32'h0000_0000);
    wr(9'h000, 1);
    mdiag = 1'b1;
    set_ch(0, 12'hff6, 10, 0, 1000, 100);
    foreach (xs[i])
      send(0, xs[i]);
    rdchk(ra(0, REG_STATUS), 32'(st[0]));
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0)
      begin
        mdiag = 1'($urandom_range(1));
        wr(9'h000, 32'(mdiag));
        cfg[0] = {4'($urandom), 4'($urandom), 4'h6};
        wr(ra(0, REG_CFG), cfg[0]);
      end
      send(0, int'($urandom_range(2400)) - 1200);
    end
    set_ch(1, 12'h000, 0, 0, 100, 5);
    send(1, 200);
    rdchk(ra(1, REG_STATUS), 32'h0000_0000);
    set_ch(1, 12'hf04, 0, 0, 100, 5);
    send(1, 200);
    set_ch(2, 12'h001, 0, 4, 2000, 5);
    send(2, 1024);
    rdchk(ra(2, REG_VALUE), 32'(fy[2]));
    send(2, 1024);
    rdchk(ra(2, REG_VALUE), 32'(fy[2]));
    set_ch(2, 12'h001, 0, 0, 2000, 5);
    send(2, -77);
    rdchk(ra(2, REG_VALUE), 32'(fy[2]));
    set_ch(2, 12'h000, 0, 8, 2000, 5);
    send(2, 300);
    rdchk(ra(2, REG_VALUE), 32'(fy[2]));
    final_report();
  end
endmodule : input_channel_alarm_conditioner_bench
